// *** rtl/mmpc_consts.svh ***
// Constants for the manual move profile controller.
// Assumes inclusion by the controller and the bench top module only.
`ifndef MMPC_CONSTS_SVH
`define MMPC_CONSTS_SVH
// Register byte offsets
`define MMPC_OFF_VEL0      8'h00
`define MMPC_OFF_ACC0      8'h04
`define MMPC_OFF_DEC0      8'h08
`define MMPC_OFF_VEL1      8'h0C
`define MMPC_OFF_ACC1      8'h10
`define MMPC_OFF_DEC1      8'h14
`define MMPC_OFF_CTRL      8'h18
`define MMPC_OFF_SETTLE    8'h1C
`define MMPC_OFF_WINDOW    8'h20
`define MMPC_OFF_STATUS    8'h24
`define MMPC_OFF_IRQ_STAT  8'h28
`define MMPC_OFF_IRQ_MASK  8'h2C
`define MMPC_OFF_CMD_VEL   8'h30
// Control field positions
`define MMPC_CTRL_TB0      0
`define MMPC_CTRL_TB1      1
`define MMPC_CTRL_STOP     2
`define MMPC_CTRL_PLUS0    3
`define MMPC_CTRL_MINUS0   4
`define MMPC_CTRL_PLUS1    5
`define MMPC_CTRL_MINUS1   6
// Status field positions
`define MMPC_ST_ACC0       0
`define MMPC_ST_AT0        1
`define MMPC_ST_DEC0       2
`define MMPC_ST_PROG0      3
`define MMPC_ST_DONE0      4
`define MMPC_ST_ACC1       5
`define MMPC_ST_AT1        6
`define MMPC_ST_DEC1       7
`define MMPC_ST_PROG1      8
`define MMPC_ST_DONE1      9
`define MMPC_ST_ANY        10
`define MMPC_ST_SETTLED    11
// Interrupt event positions
`define MMPC_EV_DONE       0
`define MMPC_EV_SETTLED    1
`define MMPC_EV_W          2
// Reset values
`define MMPC_RST_WORD      32'h0000_0000
`endif

// *** rtl/mmpc_pkg.sv ***
// Types shared by the manual move profile controller.
// Assumes the constants header is available on the include path.
package mmpc_pkg;
  // Motion state
  typedef enum logic [1:0] {
    MMPC_IDLE,
    MMPC_RAMP,
    MMPC_STOPPING
  } mmpc_state_type;
  // One parameter set
  typedef struct packed {
    logic [31:0] vel;
    logic [31:0] acc;
    logic [31:0] dec;
    logic tb_sync;
  } mmpc_set_type;
  // Per-set status flags
  typedef struct packed {
    logic done;
    logic prog;
    logic dec;
    logic at;
    logic acc;
  } mmpc_flags_type;
endpackage : mmpc_pkg

// *** rtl/mmpc_ctrl.sv ***
// Manual move profile controller with in-position detector.
// Assumes a Wishbone classic master on clk_i and pin-level inputs from
// outside the clock domain; the speed command drives a servo drive.
// Behaviour
// - Settled after stop and small error long
// - Any-set complete on either set finishing
// - Minus hold drives negative, then decelerates
// - Plus hold drives positive, then decelerates
// - Set select picks set zero or one
// - Set change ramps smoothly to new speed
// - Program stop decelerates at active rate
// - Each set owns accel and decel rates
// - Accelerating flag high while ramping up
// - At-speed flag on reaching target speed
// - Set complete on stop, cleared restart
// - In-progress high through whole profile
// - Decelerating flag during deceleration ramp
// - Program starts move at set speed
// - Time base real time or sync scaled
// - Set velocity is the target speed
`include "mmpc_consts.svh"
module mmpc_ctrl #(
  parameter int VW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pin inputs
  input wire logic plus_hold_in_i,
  input wire logic minus_hold_in_i,
  input wire logic set_select_i,
  input wire logic sync_tick_i,
  input wire logic [VW-1:0] follow_err_i,
  // Drive command and flags
  output logic [VW-1:0] cmd_vel_o,
  output logic settled_flag_o,
  output logic any_set_complete_o,
  output logic [9:0] set_flags_o,
  output logic irq_o
);
  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (VW != 32) begin : g_bad_vw
    $error("mmpc_ctrl serves only a 32-bit speed word");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  mmpc_pkg::mmpc_set_type set_reg [2]; // Parameter sets
  logic [31:0] ctrl_reg; // Time bases and program commands
  logic [31:0] settle_reg; // Settle time in ticks
  logic [31:0] window_reg; // Settle error window
  logic [`MMPC_EV_W-1:0] irq_stat_reg; // Sticky events
  logic [`MMPC_EV_W-1:0] irq_mask_reg; // Event enables
  logic [2:0] plus_sync_reg; // Pin synchronisers
  logic [2:0] minus_sync_reg;
  logic [2:0] sel_sync_reg;
  logic [2:0] tick_sync_reg; // Third stage for edge detect
  mmpc_pkg::mmpc_state_type state_reg;
  logic act_reg; // Active set
  logic dir_neg_reg; // Direction of motion
  logic signed [32:0] speed_reg; // Signed magnitude of speed
  mmpc_pkg::mmpc_flags_type flg_reg [2];
  logic any_reg;
  logic settled_reg;
  logic [31:0] settle_cnt_reg;
  logic [31:0] speed_mag; // Unsigned present speed
  logic req_plus, req_minus, req_set; // Request decode
  logic req_on;
  logic [31:0] target;
  logic step_en; // Time base gate
  logic done_ev;
  logic [31:0] rd_data;
  logic acc_hit;
  logic [31:0] abs_err;

  // Merge a write with byte enables
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wb_merge

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  assign acc_hit = cyc_i && stb_i && !ack_o;
  // One wait state, ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= acc_hit;
    end
  end

  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < 2; s++) begin
        set_reg[s] <= '0;
      end
      ctrl_reg <= `MMPC_RST_WORD;
      settle_reg <= `MMPC_RST_WORD;
      window_reg <= `MMPC_RST_WORD;
      irq_mask_reg <= '0;
    end else if (acc_hit && we_i) begin
      case (adr_i)
        `MMPC_OFF_VEL0: set_reg[0].vel <=
          wb_merge(set_reg[0].vel, dat_i, sel_i);
        `MMPC_OFF_ACC0: set_reg[0].acc <=
          wb_merge(set_reg[0].acc, dat_i, sel_i);
        `MMPC_OFF_DEC0: set_reg[0].dec <=
          wb_merge(set_reg[0].dec, dat_i, sel_i);
        `MMPC_OFF_VEL1: set_reg[1].vel <=
          wb_merge(set_reg[1].vel, dat_i, sel_i);
        `MMPC_OFF_ACC1: set_reg[1].acc <=
          wb_merge(set_reg[1].acc, dat_i, sel_i);
        `MMPC_OFF_DEC1: set_reg[1].dec <=
          wb_merge(set_reg[1].dec, dat_i, sel_i);
        `MMPC_OFF_CTRL: begin
          ctrl_reg <= wb_merge(ctrl_reg, dat_i, sel_i);
          // Time base bits copied into the sets
          if (sel_i[0]) begin
            set_reg[0].tb_sync <= dat_i[`MMPC_CTRL_TB0];
            set_reg[1].tb_sync <= dat_i[`MMPC_CTRL_TB1];
          end
        end
        `MMPC_OFF_SETTLE: settle_reg <= wb_merge(settle_reg, dat_i, sel_i);
        `MMPC_OFF_WINDOW: window_reg <= wb_merge(window_reg, dat_i, sel_i);
        `MMPC_OFF_IRQ_MASK: begin
          irq_mask_reg <= dat_i[`MMPC_EV_W-1:0];
        end
        // Other offsets ignore writes
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer
  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      `MMPC_OFF_VEL0: rd_data = set_reg[0].vel;
      `MMPC_OFF_ACC0: rd_data = set_reg[0].acc;
      `MMPC_OFF_DEC0: rd_data = set_reg[0].dec;
      `MMPC_OFF_VEL1: rd_data = set_reg[1].vel;
      `MMPC_OFF_ACC1: rd_data = set_reg[1].acc;
      `MMPC_OFF_DEC1: rd_data = set_reg[1].dec;
      `MMPC_OFF_CTRL: rd_data = ctrl_reg;
      `MMPC_OFF_SETTLE: rd_data = settle_reg;
      `MMPC_OFF_WINDOW: rd_data = window_reg;
      `MMPC_OFF_STATUS: rd_data = {20'h00000, settled_reg, any_reg,
                                   flg_reg[1], flg_reg[0]};
      `MMPC_OFF_IRQ_STAT: rd_data = {30'h00000000, irq_stat_reg};
      `MMPC_OFF_IRQ_MASK: rd_data = {30'h00000000, irq_mask_reg};
      `MMPC_OFF_CMD_VEL: rd_data = cmd_vel_o;
      // Unmapped reads as zero
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (acc_hit && !we_i) begin
      dat_o <= rd_data;
    end
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plus_sync_reg <= 3'h0;
      minus_sync_reg <= 3'h0;
      sel_sync_reg <= 3'h0;
      tick_sync_reg <= 3'h0;
    end else begin
      plus_sync_reg <= {plus_sync_reg[1:0], plus_hold_in_i};
      minus_sync_reg <= {minus_sync_reg[1:0], minus_hold_in_i};
      sel_sync_reg <= {sel_sync_reg[1:0], set_select_i};
      tick_sync_reg <= {tick_sync_reg[1:0], sync_tick_i};
    end
  end

  // ****************************************************************
  // Request decode
  // ****************************************************************
  always_comb begin
    req_plus = plus_sync_reg[1] && !minus_sync_reg[1];
    req_minus = minus_sync_reg[1] && !plus_sync_reg[1];
    req_set = sel_sync_reg[1];
    if (ctrl_reg[`MMPC_CTRL_PLUS0] ^ ctrl_reg[`MMPC_CTRL_MINUS0]) begin
      req_plus = ctrl_reg[`MMPC_CTRL_PLUS0];
      req_minus = ctrl_reg[`MMPC_CTRL_MINUS0];
      req_set = 1'b0;
    end else if (ctrl_reg[`MMPC_CTRL_PLUS1] ^
                 ctrl_reg[`MMPC_CTRL_MINUS1]) begin
      req_plus = ctrl_reg[`MMPC_CTRL_PLUS1];
      req_minus = ctrl_reg[`MMPC_CTRL_MINUS1];
      req_set = 1'b1;
    end
    req_on = (req_plus || req_minus) && !ctrl_reg[`MMPC_CTRL_STOP];
    target = set_reg[req_set].vel;
    // Synchronised base steps on sync edges only
    step_en = set_reg[act_reg].tb_sync ?
              (tick_sync_reg[1] && !tick_sync_reg[2]) : 1'b1;
    speed_mag = speed_reg[32] ? 32'h0000_0000 : speed_reg[31:0];
  end

  // ****************************************************************
  // Profile generator
  // ****************************************************************
  // One speed step per clock tick, or per sync edge when the set uses the synchronised time base
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= mmpc_pkg::MMPC_IDLE;
      act_reg <= 1'b0;
      dir_neg_reg <= 1'b0;
      speed_reg <= '0;
    end else begin
      case (state_reg)
        mmpc_pkg::MMPC_IDLE: begin
          if (req_on) begin
            state_reg <= mmpc_pkg::MMPC_RAMP;
            act_reg <= req_set;
            dir_neg_reg <= req_minus;
          end
        end
        mmpc_pkg::MMPC_RAMP: begin
          if (!req_on || (req_minus != dir_neg_reg)) begin
            state_reg <= mmpc_pkg::MMPC_STOPPING;
          end else begin
            // Set change ramps to new speed
            act_reg <= req_set;
            if (step_en) begin
              if (speed_mag < target) begin
                speed_reg <= (target - speed_mag > set_reg[req_set].acc)
                  ? speed_reg + {1'b0, set_reg[req_set].acc}
                  : {1'b0, target};
              end else if (speed_mag > target) begin
                speed_reg <= (speed_mag - target > set_reg[req_set].dec)
                  ? speed_reg - {1'b0, set_reg[req_set].dec}
                  : {1'b0, target};
              end
            end
          end
        end
        mmpc_pkg::MMPC_STOPPING: begin
          // Decelerate to zero at active rate
          if (speed_mag == 32'h0000_0000) begin
            state_reg <= mmpc_pkg::MMPC_IDLE;
          end else if (step_en) begin
            speed_reg <= (speed_mag > set_reg[act_reg].dec)
              ? speed_reg - {1'b0, set_reg[act_reg].dec} : '0;
          end
        end
        default: state_reg <= mmpc_pkg::MMPC_IDLE;
      endcase
    end
  end

  assign done_ev = (state_reg == mmpc_pkg::MMPC_STOPPING) &&
                   (speed_mag == 32'h0000_0000);

  // ****************************************************************
  // Status flags
  // ****************************************************************
  for (genvar s = 0; s < 2; s++) begin : g_flags
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flg_reg[s] <= '0;
      end else begin
        flg_reg[s].prog <= (state_reg != mmpc_pkg::MMPC_IDLE) &&
                           !done_ev && act_reg == s;
        flg_reg[s].acc <= state_reg == mmpc_pkg::MMPC_RAMP &&
                          act_reg == s && speed_mag < target;
        flg_reg[s].at <= state_reg == mmpc_pkg::MMPC_RAMP &&
                         act_reg == s && speed_mag == target;
        flg_reg[s].dec <= act_reg == s && !done_ev &&
          (state_reg == mmpc_pkg::MMPC_STOPPING ||
           (state_reg == mmpc_pkg::MMPC_RAMP && speed_mag > target));
        // Complete, cleared on restart of this set
        if (done_ev && act_reg == s) begin
          flg_reg[s].done <= 1'b1;
        end else if ((state_reg == mmpc_pkg::MMPC_IDLE && req_on &&
                      req_set == s) ||
                     (state_reg != mmpc_pkg::MMPC_IDLE && act_reg == s)) begin
          flg_reg[s].done <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      any_reg <= 1'b0;
    end else if (done_ev) begin
      any_reg <= 1'b1;
    end else if (state_reg == mmpc_pkg::MMPC_IDLE && req_on) begin
      any_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Settle detector
  // ****************************************************************
  assign abs_err = follow_err_i[31] ? (~follow_err_i + 32'h0000_0001)
                                    : follow_err_i;
  // Stopped and small error long enough
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_cnt_reg <= 32'h0000_0000;
      settled_reg <= 1'b0;
    end else if (state_reg != mmpc_pkg::MMPC_IDLE ||
                 abs_err >= window_reg) begin
      settle_cnt_reg <= 32'h0000_0000;
      settled_reg <= 1'b0;
    end else if (settle_cnt_reg < settle_reg) begin
      settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
    end else begin
      settled_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Interrupts and outputs
  // ****************************************************************
  // Sticky events, read clears, a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= ((acc_hit && !we_i && adr_i == `MMPC_OFF_IRQ_STAT)
                       ? '0 : irq_stat_reg) |
                      {(settle_cnt_reg == settle_reg) && !settled_reg &&
                       state_reg == mmpc_pkg::MMPC_IDLE &&
                       abs_err < window_reg, done_ev};
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_vel_o <= '0;
      settled_flag_o <= 1'b0;
      any_set_complete_o <= 1'b0;
      set_flags_o <= 10'h000;
      irq_o <= 1'b0;
    end else begin
      cmd_vel_o <= dir_neg_reg ? (~speed_reg[31:0] + 32'h0000_0001)
                               : speed_reg[31:0];
      settled_flag_o <= settled_reg;
      any_set_complete_o <= any_reg;
      set_flags_o <= {flg_reg[1], flg_reg[0]};
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : mmpc_ctrl

// *** testbench/mmpc_chk.sv ***
// Port checker for the manual move profile controller.
// Assumes one clock and an active-high synchronous reset.
// ****************************************************************
// Checker
// ****************************************************************
module mmpc_chk #(
  parameter int VW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Motion outputs
  input wire logic [VW-1:0] cmd_vel_o,
  input wire logic settled_flag_o,
  input wire logic any_set_complete_o,
  input wire logic [9:0] set_flags_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Acknowledge lasts one cycle and follows a request by one cycle
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held longer than one cycle");
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing one cycle after request");
  // Reset leaves speed and flags cleared
  property p_reset_clear;
    $fell(rst_i) |-> cmd_vel_o == '0 && set_flags_o == '0 &&
      !any_set_complete_o && !settled_flag_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");
  // Set zero ramps lie inside an in-progress profile
  property p_ramp_prog;
    set_flags_o[0] || set_flags_o[2] |-> set_flags_o[3];
  endproperty
  a_ramp_prog: assert property (p_ramp_prog)
    else $error("ramp flag without in-progress");
  property p_done_idle; set_flags_o[4] |-> !set_flags_o[3]; endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("complete while in progress");
  property p_acc_not_at; set_flags_o[5] |-> !set_flags_o[6]; endproperty
  a_acc_not_at: assert property (p_acc_not_at)
    else $error("accelerating and at speed together");
  property p_dec_excl;
    set_flags_o[7] |-> !set_flags_o[5] && !set_flags_o[6];
  endproperty
  a_dec_excl: assert property (p_dec_excl)
    else $error("decelerating overlaps other ramp flags");
  property p_any_cause;
    $rose(any_set_complete_o) |-> ##[0:2] set_flags_o[4] || set_flags_o[9];
  endproperty
  a_any_cause: assert property (p_any_cause)
    else $error("any-complete without a set complete");
  property p_settled_still;
    settled_flag_o |-> cmd_vel_o == '0 && $past(cmd_vel_o) == '0;
  endproperty
  a_settled_still: assert property (p_settled_still)
    else $error("settled while speed commanded");
  property p_at_steady;
    set_flags_o[1] && $past(set_flags_o[1]) |-> $stable(cmd_vel_o);
  endproperty
  a_at_steady: assert property (p_at_steady)
    else $error("speed moved while at speed");
  // Main scenarios reached
  c_at0: cover property (set_flags_o[1]);
  c_dec1: cover property (set_flags_o[7]);
  c_settled: cover property (settled_flag_o);
endmodule : mmpc_chk

bind mmpc_ctrl mmpc_chk #(.VW(VW)) i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .ack_o(ack_o),
  .cmd_vel_o(cmd_vel_o),
  .settled_flag_o(settled_flag_o),
  .any_set_complete_o(any_set_complete_o),
  .set_flags_o(set_flags_o)
);

// *** testbench/mmpc_drive_model.sv ***
// Servo drive stand-in: following error and external sync pulses.
// Assumes the speed command is registered on the same clock.
module mmpc_drive_model #(
  parameter int VW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Speed command and sync enable
  input wire logic [VW-1:0] cmd_vel_i,
  input wire logic tick_en_i,
  // Feedback to the controller
  output logic [VW-1:0] follow_err_o,
  output logic sync_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_reg; // Sync pulse divider
  always_ff @(posedge clk_i) begin
    follow_err_o <= rst_i ? '0 : VW'($signed(cmd_vel_i) >>> 2);
  end
  always_ff @(posedge clk_i) begin
    div_reg <= rst_i ? 2'h0 : div_reg + 2'h1;
    sync_tick_o <= tick_en_i && div_reg == 2'h3;
  end
endmodule : mmpc_drive_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the manual move profile controller.
// Assumes the drive model and the checker are compiled alongside.
`include "mmpc_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, cmd_vel_o, follow_err_i, rd, v1, e;
  logic ack_o, settled_flag_o, any_set_complete_o, irq_o, sync_tick_i;
  logic plus_i = 1'b0, minus_i = 1'b0, set_sel = 1'b0, tick_en = 1'b0;
  logic [9:0] set_flags_o;
  int fail_count = 0, n_compared = 0, cycles = 0;
  // Parameter table: vel, acc, dec per set, settle ticks, window
  logic [7:0] offs [8] = '{`MMPC_OFF_VEL0, `MMPC_OFF_ACC0,
    `MMPC_OFF_DEC0, `MMPC_OFF_VEL1, `MMPC_OFF_ACC1, `MMPC_OFF_DEC1,
    `MMPC_OFF_SETTLE, `MMPC_OFF_WINDOW};
  logic [31:0] vals [8] = '{32'h40, 32'h10, 32'h08, 32'h80, 32'h20,
    32'h20, 32'h04, 32'h08};
  always #25 clk_i = ~clk_i;
  mmpc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .plus_hold_in_i(plus_i), .minus_hold_in_i(minus_i),
    .set_select_i(set_sel), .sync_tick_i(sync_tick_i),
    .follow_err_i(follow_err_i), .cmd_vel_o(cmd_vel_o),
    .settled_flag_o(settled_flag_o),
    .any_set_complete_o(any_set_complete_o),
    .set_flags_o(set_flags_o), .irq_o(irq_o));
  mmpc_drive_model i_drive (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_vel_i(cmd_vel_o), .tick_en_i(tick_en),
    .follow_err_o(follow_err_i), .sync_tick_o(sync_tick_i));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic Wishbone cycle, read data left in rd
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // Flag k (12 is speed, 13 interrupt) read at the current edge
  function automatic logic [31:0] probe(input int k);
    logic [13:0] f;
    f = {irq_o, 1'b0, settled_flag_o, any_set_complete_o, set_flags_o};
    return k == 12 ? cmd_vel_o : {31'h0, f[k]};
  endfunction : probe
  // Bounded wait for a value, then compare
  task automatic wt(input int k, input logic [31:0] exp);
    for (int n = 0; n < 400 && probe(k) !== exp; n++) @(posedge clk_i);
    chk(probe(k), exp);
  endtask : wt
  // Speed change over one clock once ramp flag k is seen
  task automatic rate(input int k, input logic [31:0] d);
    wt(k, 1);
    v1 = cmd_vel_o;
    @(posedge clk_i);
    chk(cmd_vel_o - v1, d);
  endtask : rate
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(cmd_vel_o, 32'h0);
    foreach (offs[i]) wb(1'b1, offs[i], vals[i]);
    foreach (offs[i]) begin
      wb(1'b0, offs[i], 32'h0);
      chk(rd, vals[i]);
    end
    wb(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    // Idle with no error: only the settled bit is up by now
    wb(1'b0, `MMPC_OFF_STATUS, 32'h0);
    chk(rd, 32'h1 << `MMPC_ST_SETTLED);
    plus_i <= 1'b1;
    rate(`MMPC_ST_ACC0, 32'h10);
    chk(set_flags_o[`MMPC_ST_PROG0], 1'b1);
    wt(`MMPC_ST_AT0, 1);
    chk(cmd_vel_o, 32'h40);
    chk(set_flags_o[`MMPC_ST_ACC0], 1'b0);
    plus_i <= 1'b0;
    rate(`MMPC_ST_DEC0, -32'h08);
    wt(`MMPC_ST_DONE0, 1);
    chk(cmd_vel_o, 32'h0);
    chk(set_flags_o[`MMPC_ST_PROG0], 1'b0);
    chk(set_flags_o[`MMPC_ST_DEC0], 1'b0);
    wt(10, 1);
    wt(11, 1);
    chk(irq_o, 1'b0);
    wb(1'b1, `MMPC_OFF_IRQ_MASK, 32'h3);
    wt(13, 1);
    wb(1'b0, `MMPC_OFF_IRQ_STAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    set_sel <= 1'b1;
    minus_i <= 1'b1;
    wt(`MMPC_ST_AT1, 1);
    chk(cmd_vel_o, -32'h80);
    chk(any_set_complete_o, 1'b0);
    set_sel <= 1'b0;
    wt(12, -32'h40);
    chk(set_flags_o[`MMPC_ST_DONE0], 1'b0);
    minus_i <= 1'b0;
    wt(12, 0);
    wt(10, 1);
    plus_i <= 1'b1;
    minus_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(cmd_vel_o, 32'h0);
    plus_i <= 1'b0;
    minus_i <= 1'b0;
    // Program starts for both sets and both directions, then stop
    for (int b = 3; b < 7; b++) begin
      e = b < 5 ? 32'h40 : 32'h80;
      e = b[0] ? e : -e;
      wb(1'b1, `MMPC_OFF_CTRL, 32'h1 << b);
      wt(b < 5 ? 1 : 6, 1);
      chk(cmd_vel_o, e);
      chk(set_flags_o[b < 5 ? 4 : 9], 1'b0);
      wb(1'b1, `MMPC_OFF_CTRL, (32'h1 << b) | 32'h4);
      v1 = b < 5 ? 32'h08 : 32'h20;
      rate(b < 5 ? 2 : 7, b[0] ? -v1 : v1);
      wt(b < 5 ? 4 : 9, 1);
      chk(cmd_vel_o, 32'h0);
      wb(1'b1, `MMPC_OFF_CTRL, 32'h0);
    end
    wb(1'b1, `MMPC_OFF_CTRL, 32'h1);
    plus_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(cmd_vel_o, 32'h0);
    tick_en <= 1'b1;
    wt(`MMPC_ST_AT0, 1);
    chk(cmd_vel_o, 32'h40);
    plus_i <= 1'b0;
    wt(`MMPC_ST_DONE0, 1);
    end_of_test();
  end
endmodule : tb_top
